// File: rtl/ebm_master.v
// External bus master: dynamic bus sizing, strobes and cycle termination
`timescale 1ns/1ps
`include "ebm_map.vh"

// How it works
// - Word and long operands must be word aligned, so a word or long request to an odd address is refused.
// - Only a single byte is ever moved at an odd address.
// - An 8-bit port makes the master split words and longs into successive byte cycles.
// - Ports of 8 and 16 bits are both served, in asynchronous and synchronous mode alike.
// - The master drives an address strobe and a separate data strobe.
// - In asynchronous mode the acknowledges are synchronised before use, adding latency.
// - In synchronous mode the acknowledges bypass synchronisation and a cycle can end in three clocks.
// - With fast termination enabled each external access completes in two clocks.
// - The bus inputs, data and port size acknowledge, are captured on the falling edge of the clock.
// - A level caught while changing is resolved to a definite value by a flip-flop before use.
// - The bus protocol is the same whichever master owns the bus, and cycles are named by the owner.
// - The transfer size output shows bytes remaining: 01 byte, 10 word, 11 three bytes, 00 long.
// - The address strobe is asserted shortly after the address is driven at cycle start.
module ebm_master (
    input  wire        core_clk_i,
    input  wire        reset_i,
    // User request side
    input  wire        req_valid_i,
    output wire        req_ready_o,
    input  wire [31:0] req_addr_i,
    input  wire [1:0]  req_size_i,
    input  wire        req_write_i,
    input  wire [31:0] req_wdata_i,
    input  wire        sync_mode_i,
    input  wire        fast_term_i,
    input  wire        fast_port8_i,
    output reg         rsp_valid_o,
    output reg         rsp_err_o,
    output reg  [31:0] rsp_rdata_o,
    // External bus pins
    output reg  [31:0] addr_o,
    output reg  [1:0]  transfer_size_o,
    output reg         rw_o,
    output wire        address_strobe_n_o,
    output wire        data_strobe_n_o,
    output reg  [15:0] data_o,
    output wire        data_oe_n_o,
    input  wire [15:0] data_i,
    input  wire [1:0]  port_size_ack_n_i
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_ADDR = 3'h1;
    localparam [2:0] ST_STRB = 3'h2;
    localparam [2:0] ST_WAIT = 3'h3;
    localparam [2:0] ST_END  = 3'h4;

    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    reg  [2:0]  rem_q;
    reg  [2:0]  rem_d;
    reg  [31:0] buf_q;
    reg  [31:0] buf_d;
    reg  [31:0] addr_d;
    reg         write_q;
    reg         sync_q;
    reg         fast_q;
    reg         fport8_q;
    reg  [15:0] data_fe_q;
    reg  [15:0] data_d;
    reg         rsp_valid_d;
    reg         rsp_err_d;
    reg         step;
    reg  [2:0]  moved;
    wire [1:0]  ack_sync;
    wire [1:0]  ack_direct;
    wire [1:0]  ack_n;
    wire        ack_seen;
    wire        port8;
    wire        term;
    wire        strobing;

    // Bytes left to move shown on the size pins
    function [1:0] size_code;
        input [2:0] rem;
        begin
            case (rem)
                3'h1:    size_code = `EBM_SIZE_BYTE;
                3'h2:    size_code = `EBM_SIZE_WORD;
                3'h3:    size_code = `EBM_SIZE_THREE;
                default: size_code = `EBM_SIZE_LONG;
            endcase
        end
    endfunction

    // Write lanes: a lone byte is replicated so either half of the port sees it
    function [15:0] lane_data;
        input [31:0] b;
        input [2:0]  rem;
        input        odd;
        begin
            if (odd || rem == `EBM_REM_ONE) begin
                lane_data = {b[31:24], b[31:24]};
            end else begin
                lane_data = b[31:16];
            end
        end
    endfunction

    ebm_in_sync #(
        .W(2)
    ) u_ack_sync (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .pin_i      (port_size_ack_n_i),
        .sync_o     (ack_sync),
        .direct_o   (ack_direct)
    );

    // Read data is captured on every falling edge, without regard to the acknowledge
    always @(negedge core_clk_i) begin
        if (reset_i) begin
            data_fe_q <= 16'h0000;
        end else begin
            data_fe_q <= data_i;
        end
    end

    assign ack_n    = sync_q ? ack_direct : ack_sync;
    assign ack_seen = (ack_n != `EBM_ACK_IDLE);
    assign port8    = fast_q ? fport8_q : ack_n[`EBM_ACK_WIDE_BIT];
    assign term     = fast_q ? (state_q == ST_STRB) : ack_seen;
    assign strobing = (state_q == ST_STRB) || (state_q == ST_WAIT);

    assign req_ready_o        = (state_q == ST_IDLE);
    assign address_strobe_n_o = ~strobing;
    // Write data strobe trails the address strobe by a clock except in synchronous or fast termination mode
    assign data_strobe_n_o    = ~(strobing && (!write_q || state_q == ST_WAIT
                                 || sync_q || fast_q));
    assign data_oe_n_o        = ~(write_q && state_q != ST_IDLE);

    always @* begin
        state_d     = state_q;
        rem_d       = rem_q;
        buf_d       = buf_q;
        addr_d      = addr_o;
        data_d      = data_o;
        rsp_valid_d = 1'b0;
        rsp_err_d   = 1'b0;
        step        = 1'b0;
        moved       = `EBM_REM_ONE;
        case (state_q)
            ST_IDLE: begin
                if (req_valid_i) begin
                    if (req_size_i != `EBM_SIZE_BYTE && req_addr_i[0]) begin
                        rsp_valid_d = 1'b1;
                        rsp_err_d   = 1'b1;
                    end else begin
                        addr_d = req_addr_i;
                        if (req_size_i == `EBM_SIZE_BYTE) begin
                            rem_d = `EBM_REM_ONE;
                            buf_d = {req_wdata_i[7:0], 24'h000000};
                        end else if (req_size_i == `EBM_SIZE_WORD) begin
                            rem_d = `EBM_REM_TWO;
                            buf_d = {req_wdata_i[15:0], 16'h0000};
                        end else begin
                            rem_d = `EBM_REM_FOUR;
                            buf_d = req_wdata_i;
                        end
                        if (!req_write_i) begin
                            buf_d = 32'h00000000;
                        end
                        state_d = ST_ADDR;
                    end
                end
            end
            ST_ADDR: begin
                // A stale synchronised acknowledge from the last cycle must clear first
                if (fast_q || !ack_seen) begin
                    data_d  = lane_data(buf_q, rem_q, addr_o[0]);
                    state_d = ST_STRB;
                end
            end
            ST_STRB, ST_WAIT: begin
                if (term) begin
                    step = 1'b1;
                    if (fast_q) begin
                        state_d = ST_IDLE;
                    end else begin
                        state_d = ST_END;
                    end
                end else begin
                    state_d = ST_WAIT;
                end
            end
            default: begin
                if (rem_q == `EBM_REM_NONE) begin
                    state_d     = ST_IDLE;
                    rsp_valid_d = 1'b1;
                end else begin
                    state_d = ST_ADDR;
                end
            end
        endcase
        if (step) begin
            // One byte per cycle at an odd address or on an 8-bit port
            if (port8 || addr_o[0] || rem_q == `EBM_REM_ONE) begin
                moved = `EBM_REM_ONE;
                if (port8 || !addr_o[0]) begin
                    buf_d = {buf_q[23:0], data_fe_q[15:8]};
                end else begin
                    buf_d = {buf_q[23:0], data_fe_q[7:0]};
                end
            end else begin
                moved = `EBM_REM_TWO;
                buf_d = {buf_q[15:0], data_fe_q};
            end
            rem_d  = rem_q - moved;
            addr_d = addr_o + {29'h00000000, moved};
            if (fast_q) begin
                if (rem_d == `EBM_REM_NONE) begin
                    rsp_valid_d = 1'b1;
                end else begin
                    state_d = ST_ADDR;
                end
            end
        end
    end

    always @(posedge core_clk_i) begin
        if (reset_i) begin
            state_q         <= ST_IDLE;
            rem_q           <= `EBM_REM_NONE;
            buf_q           <= 32'h00000000;
            addr_o          <= 32'h00000000;
            data_o          <= 16'h0000;
            write_q         <= 1'b0;
            sync_q          <= 1'b0;
            fast_q          <= 1'b0;
            fport8_q        <= 1'b0;
            rw_o            <= `EBM_RW_READ;
            transfer_size_o <= `EBM_SIZE_LONG;
            rsp_valid_o     <= 1'b0;
            rsp_err_o       <= 1'b0;
            rsp_rdata_o     <= 32'h00000000;
        end else begin
            state_q         <= state_d;
            rem_q           <= rem_d;
            buf_q           <= buf_d;
            addr_o          <= addr_d;
            data_o          <= data_d;
            transfer_size_o <= size_code(rem_d);
            rsp_valid_o     <= rsp_valid_d;
            rsp_err_o       <= rsp_err_d;
            if (state_q == ST_IDLE && state_d == ST_ADDR) begin
                // Bus and mode settings hold for the whole operand, as for any owner
                write_q  <= req_write_i;
                rw_o     <= ~req_write_i;
                sync_q   <= sync_mode_i;
                fast_q   <= fast_term_i;
                fport8_q <= fast_port8_i;
            end
            if (rsp_valid_d && !rsp_err_d && !write_q) begin
                rsp_rdata_o <= buf_d;
            end
        end
    end
endmodule // ebm_master

// File: rtl/ebm_map.vh
// Constants for the external bus master: size codes, port ack bits and idle levels
`ifndef EBM_MAP_VH
`define EBM_MAP_VH

// Transfer size encoding of the bytes still to be moved
`define EBM_SIZE_BYTE   2'h1
`define EBM_SIZE_WORD   2'h2
`define EBM_SIZE_THREE  2'h3
`define EBM_SIZE_LONG   2'h0

// Bit of the port size acknowledge pair that, when negated, marks an 8-bit port
`define EBM_ACK_WIDE_BIT 1

// Bytes remaining encodings
`define EBM_REM_NONE    3'h0
`define EBM_REM_ONE     3'h1
`define EBM_REM_TWO     3'h2
`define EBM_REM_FOUR    3'h4

// Idle and reset levels of the bus pins
`define EBM_STROBE_IDLE 1'h1
`define EBM_ACK_IDLE    2'h3
`define EBM_RW_READ     1'h1

`endif

// File: rtl/ebm_in_sync.v
// Falling edge input sampler: three stage synchroniser plus a single direct sample
`timescale 1ns/1ps
module ebm_in_sync #(
    parameter W = 2
) (
    input  wire         core_clk_i,
    input  wire         reset_i,
    input  wire [W-1:0] pin_i,
    output reg  [W-1:0] sync_o,
    output reg  [W-1:0] direct_o
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;

    // Every stage captures on the falling edge; the first stage feeds only the second
    always @(negedge core_clk_i) begin
        if (reset_i) begin
            s1_q     <= {W{1'b1}};
            s2_q     <= {W{1'b1}};
            s3_q     <= {W{1'b1}};
            sync_o   <= {W{1'b1}};
            direct_o <= {W{1'b1}};
        end else begin
            s1_q     <= pin_i;
            s2_q     <= s1_q;
            s3_q     <= s2_q;
            direct_o <= pin_i;
            if (s2_q == s3_q) begin
                sync_o <= s3_q;
            end
        end
    end
endmodule // ebm_in_sync

// File: verification/ebm_slave_model.sv
// Behavioural memory slave answering the external bus master
`timescale 1ns/1ps
module ebm_slave_model (
    input  wire        core_clk_i,
    input  wire        reset_i,
    input  wire        port8_i,
    input  wire [3:0]  wait_i,
    input  wire [31:0] addr_i,
    input  wire        address_strobe_n_i,
    output wire [15:0] data_o,
    output wire [1:0]  ack_n_o
);
    reg  [3:0]  cnt_q;
    wire [7:0]  even_b = {addr_i[7:1], 1'b0} ^ 8'h5A;
    wire [7:0]  odd_b  = {addr_i[7:1], 1'b1} ^ 8'h5A;
    wire [15:0] val    = port8_i ? {addr_i[7:0] ^ 8'h5A, 8'h00} : {even_b, odd_b};
    // Answer only after the chosen wait; levels move just after rising edges
    wire        hit    = !address_strobe_n_i && cnt_q >= wait_i;
    assign ack_n_o = hit ? (port8_i ? 2'h2 : 2'h0) : 2'h3;
    // Released bus shows the inverse of the value for the current address
    assign data_o  = hit ? val : ~val;
    always @(posedge core_clk_i) begin
        cnt_q <= (reset_i || address_strobe_n_i) ? 4'h0 : cnt_q + 4'h1;
    end
endmodule // ebm_slave_model

// File: verification/ebm_master_assertions.sv
// Pin timing checks for the external bus master
`timescale 1ns/1ps
module ebm_master_assertions (
    input wire        core_clk_i,
    input wire        reset_i,
    input wire        req_valid_i,
    input wire        req_ready_o,
    input wire [31:0] req_addr_i,
    input wire [1:0]  req_size_i,
    input wire        sync_mode_i,
    input wire        fast_term_i,
    input wire        rsp_valid_o,
    input wire        rsp_err_o,
    input wire [31:0] addr_o,
    input wire [1:0]  transfer_size_o,
    input wire        rw_o,
    input wire        address_strobe_n_o,
    input wire        data_strobe_n_o,
    input wire [1:0]  port_size_ack_n_i
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    wire odd_req = req_valid_i && req_ready_o && req_addr_i[0];
    sequence as_fall;
        $fell(address_strobe_n_o);
    endsequence
    sequence as_end;
        ##1 address_strobe_n_o;
    endsequence
    odd_refuse_a: assert property (
        odd_req && req_size_i != 2'h1 |-> ##[1:2] (rsp_valid_o && rsp_err_o))
        else $error("odd word not refused");
    odd_no_bus_a: assert property (
        odd_req && req_size_i != 2'h1 |=> req_ready_o && address_strobe_n_o ##1 address_strobe_n_o)
        else $error("bus cycle on refused request");
    odd_byte_a: assert property (
        odd_req && req_size_i == 2'h1 |-> ##[2:4]
        (!address_strobe_n_o && addr_o[0] && transfer_size_o == 2'h1))
        else $error("odd byte cycle wrong");
    addr_lead_a: assert property (
        as_fall |-> $stable(addr_o) && $stable(transfer_size_o) && $stable(rw_o))
        else $error("address not set before strobe");
    bus_hold_a: assert property (
        !address_strobe_n_o |=> address_strobe_n_o || ($stable(addr_o) && $stable(transfer_size_o)))
        else $error("address or size moved under strobe");
    read_strb_a: assert property (
        rw_o && !address_strobe_n_o |-> !data_strobe_n_o)
        else $error("read data strobe missing");
    ds_inside_a: assert property (
        !data_strobe_n_o |-> !address_strobe_n_o)
        else $error("data strobe outside address strobe");
    wait_ack_a: assert property (
        !fast_term_i && !address_strobe_n_o && port_size_ack_n_i == 2'h3 |=> !address_strobe_n_o)
        else $error("cycle ended without acknowledge");
    sync_three_a: assert property (
        (sync_mode_i && !fast_term_i && port_size_ack_n_i != 2'h3) ##0 as_fall |-> as_end)
        else $error("sync cycle longer than three clocks");
    fast_two_a: assert property (
        fast_term_i ##0 as_fall |-> as_end)
        else $error("fast cycle longer than two clocks");
    async_lat_a: assert property (
        (!sync_mode_i && !fast_term_i) ##0 as_fall |-> ##1 !address_strobe_n_o)
        else $error("async acknowledge used unsynchronised");
    idle_a: assert property (
        req_ready_o |-> address_strobe_n_o && data_strobe_n_o)
        else $error("strobe active while idle");
endmodule // ebm_master_assertions
bind ebm_master ebm_master_assertions u_chk (.core_clk_i, .reset_i, .req_valid_i, .req_ready_o,
    .req_addr_i, .req_size_i, .sync_mode_i, .fast_term_i, .rsp_valid_o, .rsp_err_o, .addr_o,
    .transfer_size_o, .rw_o, .address_strobe_n_o, .data_strobe_n_o, .port_size_ack_n_i);

// File: verification/tb_external_bus_master_timing.sv
// Self-checking bench for the external bus master
`timescale 1ns/1ps
module tb_external_bus_master_timing;
    reg         core_clk_i = 0;
    reg         reset_i = 1;
    reg         req_valid_i = 0;
    reg  [31:0] req_addr_i = 0;
    reg  [1:0]  req_size_i = 1;
    reg         req_write_i = 0;
    reg  [31:0] req_wdata_i = 0;
    reg         sync_mode_i = 1;
    reg         fast_term_i = 0;
    reg         fast_port8_i = 0;
    reg  [3:0]  wait_n = 0;
    wire        req_ready_o, rsp_valid_o, rsp_err_o, rw_o, data_oe_n_o;
    wire        address_strobe_n_o, data_strobe_n_o;
    wire [31:0] rsp_rdata_o, addr_o;
    wire [1:0]  transfer_size_o, port_size_ack_n_i;
    wire [15:0] data_o, data_i;
    integer     n_fail = 0;
    integer     n_checks = 0;
    integer     cyc = 0;
    integer     i;
    reg         as_q = 1;
    reg         err;
    reg  [31:0] qa[$];
    reg  [1:0]  qs[$];
    reg  [15:0] qw[$];
    reg  [2:0]  qo[$];
    always #10 core_clk_i = ~core_clk_i;
    ebm_master uut (.core_clk_i, .reset_i, .req_valid_i, .req_ready_o, .req_addr_i, .req_size_i,
        .req_write_i, .req_wdata_i, .sync_mode_i, .fast_term_i, .fast_port8_i, .rsp_valid_o,
        .rsp_err_o, .rsp_rdata_o, .addr_o, .transfer_size_o, .rw_o, .address_strobe_n_o,
        .data_strobe_n_o, .data_o, .data_oe_n_o, .data_i, .port_size_ack_n_i);
    ebm_slave_model slave (.core_clk_i, .reset_i, .port8_i(fast_port8_i), .wait_i(wait_n),
        .addr_i(addr_o), .address_strobe_n_i(address_strobe_n_o), .data_o(data_i),
        .ack_n_o(port_size_ack_n_i));
    function [7:0] f(input [31:0] a);
        f = a[7:0] ^ 8'h5A;
    endfunction
    task test_done; begin
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end endtask
    always @(posedge core_clk_i) begin
        cyc = cyc + 1;
        if (cyc > 4000) begin
            n_fail = n_fail + 1;
            test_done;
        end
        if (!address_strobe_n_o && as_q) begin
            qa.push_back(addr_o);
            qs.push_back(transfer_size_o);
            qw.push_back(data_o);
            qo.push_back({rw_o, data_oe_n_o, data_strobe_n_o});
        end
        as_q = address_strobe_n_o;
    end
    task chk(input [63:0] got, input [63:0] exp); begin
        n_checks = n_checks + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    end endtask
    task op(input [31:0] a, input [1:0] s, input w, input [31:0] wd, input sm, input ft,
            input p8); begin
        qa.delete();
        qs.delete();
        qw.delete();
        qo.delete();
        @(negedge core_clk_i);
        req_addr_i = a;
        req_size_i = s;
        req_write_i = w;
        req_wdata_i = wd;
        sync_mode_i = sm;
        fast_term_i = ft;
        fast_port8_i = p8;
        req_valid_i = 1;
        @(negedge core_clk_i);
        req_valid_i = 0;
        for (i = 0; i < 100 && rsp_valid_o !== 1'b1; i = i + 1)
            @(negedge core_clk_i);
        chk(rsp_valid_o, 1);
        err = rsp_err_o;
    end endtask
    task t_sync16; begin
        wait_n = 0;
        op(32'h0000_0100, 2'h2, 0, 0, 1, 0, 0);
        chk(qa.size(), 1);
        chk(qs[0], 2'h2);
        chk(qo[0], 3'h6);
        chk(rsp_rdata_o[15:0], {f(32'h100), f(32'h101)});
        $display("test sync 16-bit word read done");
    end endtask
    task t_write8; begin
        op(32'h0000_0200, 2'h2, 1, 32'h1234, 1, 0, 1);
        chk(qa.size(), 2);
        chk(qa[1], 32'h201);
        chk({qs[0], qs[1]}, 4'h9);
        chk({qw[0], qw[1]}, 32'h1234_3434);
        chk({qo[0], qo[1]}, 6'h00);
        chk(rsp_rdata_o, 32'h0000_5A5B);
        $display("test sync 8-bit word write done");
    end endtask
    task t_odd; begin
        op(32'h0000_0301, 2'h2, 0, 0, 1, 0, 0);
        chk({err, qa.size()}, {1'b1, 32'h0});
        op(32'h0000_0303, 2'h0, 0, 0, 1, 0, 0);
        chk({err, qa.size()}, {1'b1, 32'h0});
        op(32'h0000_0303, 2'h1, 0, 0, 1, 0, 0);
        chk({err, qs[0], qa[0]}, {3'h1, 32'h303});
        chk(rsp_rdata_o[7:0], f(32'h303));
        $display("test odd address done");
    end endtask
    task t_async; begin
        wait_n = 2;
        op(32'h0000_0400, 2'h0, 0, 0, 0, 0, 0);
        chk({qs[0], qs[1], qa[1]}, {4'h2, 32'h402});
        chk(rsp_rdata_o, {f(32'h400), f(32'h401), f(32'h402), f(32'h403)});
        op(32'h0000_0410, 2'h2, 1, 32'hBEEF, 0, 0, 0);
        chk({qo[0], qw[0]}, {3'h1, 16'hBEEF});
        $display("test async long read and word write done");
    end endtask
    task t_fast; begin
        wait_n = 0;
        op(32'h0000_0500, 2'h0, 0, 0, 1, 1, 1);
        chk(qa.size(), 4);
        for (int k = 0; k < 4; k++) begin
            chk({qs[k], qa[k]}, {2'(4 - k), 32'h500 + k});
        end
        chk(rsp_rdata_o, {f(32'h500), f(32'h501), f(32'h502), f(32'h503)});
        op(32'h0000_0600, 2'h0, 1, 32'hA1B2_C3D4, 1, 1, 0);
        chk({qs[0], qs[1], qw[0], qw[1]}, {4'h2, 32'hA1B2_C3D4});
        $display("test fast long read and write done");
    end endtask
    initial begin
        repeat (3) @(negedge core_clk_i);
        reset_i <= 0;
        chk({address_strobe_n_o, data_strobe_n_o, rw_o, data_oe_n_o}, 4'hF);
        t_sync16;
        t_write8;
        t_odd;
        t_async;
        t_fast;
        test_done;
    end
endmodule // tb_external_bus_master_timing
